// ==== inc/ocd_map.vh ====
// constants for the octal dac serial command port
`ifndef OCD_MAP_VH
`define OCD_MAP_VH
`define OCD_SHIFT_W      32
`define OCD_CODE_W       16
`define OCD_NUM_CH       8
`define OCD_CMD_HI       23
`define OCD_CMD_LO       20
`define OCD_ADR_HI       19
`define OCD_ADR_LO       16
`define OCD_DAT_HI       15
`define OCD_DAT_LO       0
`define OCD_CMD_WRITE    4'h0
`define OCD_CMD_UPDATE   4'h1
`define OCD_CMD_WR_UPALL 4'h2
`define OCD_CMD_WR_UP    4'h3
`define OCD_CMD_PDOWN    4'h4
`define OCD_CMD_NOP      4'hf
`define OCD_ADR_ALL      4'hf
`define OCD_ADR_MAX      4'h7
`define OCD_SHIFT_RST    32'h0000_0000
`define OCD_CODE_RST     16'h0000
`define OCD_MASK_NONE    8'h00
`define OCD_MASK_ALL     8'hff
`define OCD_MASK_ONE     8'h01
`endif

// ==== verilog/ocd_sync.v ====
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module ocd_sync (
  input  wire clk_sys_i,  // system clock
  input  wire rst_n_i,    // async reset, active low
  input  wire d_i,        // asynchronous level
  output reg  q_o         // synchronised level
);
  reg meta;
  // first stage is read only by the second
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ==== verilog/ocd_edge.v ====
// edge detector on a synchronised level
`timescale 1ns/1ps
module ocd_edge (
  input  wire clk_sys_i,  // system clock
  input  wire rst_n_i,    // async reset, active low
  input  wire lvl_i,      // synchronised level
  input  wire init_i,     // level assumed before first sample
  output wire rise_o,     // one-cycle pulse on rising edge
  output wire fall_o      // one-cycle pulse on falling edge
);
  reg prev;
  reg seeded;
  // seeded flag lets init_i stand in for prev until the first sample after reset
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev   <= 1'b0;
      seeded <= 1'b0;
    end else begin
      prev   <= lvl_i;
      seeded <= 1'b1;
    end
  end
  // before the first sample the idle level stands in, so reset gives no false edge
  assign rise_o = lvl_i & ~(seeded ? prev : init_i);
  assign fall_o = ~lvl_i & (seeded ? prev : init_i);
endmodule

// ==== verilog/ocd_port.v ====
// serial command port of an octal dac: shift register, decoder, channel registers
`timescale 1ns/1ps
`include "ocd_map.vh"
module ocd_port (
  input  wire         clk_sys_i,         // 100 MHz system clock
  input  wire         resetn_i,          // power-on reset, async, active low
  input  wire         async_clear_n_i,   // clear pin, active low
  input  wire         load_select_n_i,   // chip select / load pin, active low
  input  wire         shift_clock_i,     // serial shift clock pin
  input  wire         serial_in_i,       // serial data pin
  output reg          serial_out_chain_o,// daisy-chain output, always driven
  output reg  [127:0] dac_code_o,        // active codes, channel a in low 16 bits
  output reg  [7:0]   power_down_o,      // per-channel power-down state
  output reg          exec_o             // pulse when a frame was executed
);
  wire       rst_n;
  wire       clr_s;
  wire       sel_n_s;
  wire       sel_s;
  wire       sck_s;
  wire       sdi_s;
  wire       sck_rise;
  wire       sck_fall;
  wire       sel_rise;
  reg [`OCD_SHIFT_W-1:0] shreg;
  reg [`OCD_CODE_W-1:0]  in_reg [0:`OCD_NUM_CH-1];
  reg [`OCD_CODE_W-1:0]  dac_reg [0:`OCD_NUM_CH-1];
  reg [7:0]  pd;
  wire [3:0] cmd;
  wire [3:0] adr;
  wire [`OCD_CODE_W-1:0] dat;
  wire [7:0] sel_mask;
  reg  [7:0] next_wr_mask;
  reg  [7:0] next_up_mask;
  reg  [7:0] next_pd_set;
  integer    i;
  integer    j;

  // channel decode: one channel, all, or none for reserved codes
  function [7:0] ch_mask;
    input [3:0] a;
    begin
      if (a == `OCD_ADR_ALL)
        ch_mask = `OCD_MASK_ALL;
      else if (a <= `OCD_ADR_MAX)
        ch_mask = `OCD_MASK_ONE << a[2:0];
      else
        ch_mask = `OCD_MASK_NONE;
    end
  endfunction

  // clear pin is treated like reset; both are async and zero the registers
  assign rst_n = resetn_i & async_clear_n_i;

  // pins pass two flops; the clear is also synchronised for its level view
  ocd_sync u_sync_clr (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (resetn_i),
    .d_i       (async_clear_n_i),
    .q_o       (clr_s)
  );
  // select is synced inverted so its reset value means deselected
  ocd_sync u_sync_sel (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .d_i       (~load_select_n_i),
    .q_o       (sel_s)
  );
  assign sel_n_s = ~sel_s;
  ocd_sync u_sync_sck (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .d_i       (shift_clock_i),
    .q_o       (sck_s)
  );
  ocd_sync u_sync_sdi (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .d_i       (serial_in_i),
    .q_o       (sdi_s)
  );

  // edges found on the system clock; sck must stay below a quarter of it
  ocd_edge u_edge_sck (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .lvl_i     (sck_s),
    .init_i    (1'b0),
    .rise_o    (sck_rise),
    .fall_o    (sck_fall)
  );
  ocd_edge u_edge_sel (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .lvl_i     (sel_n_s),
    .init_i    (1'b1),
    .rise_o    (sel_rise),
    .fall_o    ()
  );

  // fields come from the low 24 bits, so leading filler falls off the top
  assign cmd      = shreg[`OCD_CMD_HI:`OCD_CMD_LO];
  assign adr      = shreg[`OCD_ADR_HI:`OCD_ADR_LO];
  assign dat      = shreg[`OCD_DAT_HI:`OCD_DAT_LO];
  assign sel_mask = ch_mask(adr);

  // shift only while selected, one bit per rising edge, msb first
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= `OCD_SHIFT_RST;
    end else if (!sel_n_s && sck_rise) begin
      shreg <= {shreg[`OCD_SHIFT_W-2:0], sdi_s};
    end
  end

  // chain output follows the top bit on falling edges, selected or not
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_out_chain_o <= 1'b0;
    end else if (sck_fall) begin
      serial_out_chain_o <= shreg[`OCD_SHIFT_W-1];
    end
  end

  // command decode into write, update and power-down masks
  always @* begin
    next_wr_mask = `OCD_MASK_NONE;
    next_up_mask = `OCD_MASK_NONE;
    next_pd_set  = `OCD_MASK_NONE;
    case (cmd)
      `OCD_CMD_WRITE: begin
        next_wr_mask = sel_mask;
      end
      `OCD_CMD_UPDATE: begin
        next_up_mask = sel_mask;
      end
      `OCD_CMD_WR_UPALL: begin
        next_wr_mask = sel_mask;
        next_up_mask = `OCD_MASK_ALL;
      end
      `OCD_CMD_WR_UP: begin
        next_wr_mask = sel_mask;
        next_up_mask = sel_mask;
      end
      `OCD_CMD_PDOWN: begin
        next_pd_set  = sel_mask;
      end
      `OCD_CMD_NOP: begin
        next_wr_mask = `OCD_MASK_NONE;
      end
      default: begin
        next_wr_mask = `OCD_MASK_NONE; // reserved codes do nothing
      end
    endcase
  end

  // execute on select rising edge; write lands before update in the same step
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      for (i = 0; i < `OCD_NUM_CH; i = i + 1) begin
        in_reg[i]  <= `OCD_CODE_RST;
        dac_reg[i] <= `OCD_CODE_RST;
      end
      pd <= `OCD_MASK_NONE;
    end else if (sel_rise) begin
      for (i = 0; i < `OCD_NUM_CH; i = i + 1) begin
        if (next_wr_mask[i])
          in_reg[i] <= dat;
        if (next_up_mask[i]) begin
          dac_reg[i] <= next_wr_mask[i] ? dat : in_reg[i];
          pd[i]      <= 1'b0;
        end else if (next_pd_set[i]) begin
          pd[i]      <= 1'b1;
        end
      end
    end
  end

  // outputs registered from the channel state, exec from the select rise and synced clear
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      dac_code_o   <= {(`OCD_NUM_CH*`OCD_CODE_W){1'b0}};
      power_down_o <= `OCD_MASK_NONE;
      exec_o       <= 1'b0;
    end else begin
      for (j = 0; j < `OCD_NUM_CH; j = j + 1)
        dac_code_o[j*`OCD_CODE_W +: `OCD_CODE_W] <= dac_reg[j];
      power_down_o <= pd;
      exec_o       <= sel_rise & clr_s;
    end
  end
endmodule

// ==== bench/ocd_port_properties.sv ====
// checker on the serial command port outputs
`timescale 1ns/1ps
module ocd_port_properties (
  input wire logic         clk_sys_i,          // clock
  input wire logic         resetn_i,           // reset
  input wire logic         async_clear_n_i,    // clear
  input wire logic         load_select_n_i,    // select
  input wire logic         shift_clock_i,      // shift clock
  input wire logic         serial_in_i,        // data in
  input wire logic         serial_out_chain_o, // chain out
  input wire logic [127:0] dac_code_o,         // codes
  input wire logic [7:0]   power_down_o,       // power-down
  input wire logic         exec_o              // executed
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // exec is one pulse, only once select has stood high a while
  a_exec_pulse: assert property (exec_o |=> !exec_o)
    else $error("exec too long");
  a_exec_sel_high: assert property (exec_o |-> load_select_n_i && $past(load_select_n_i, 3))
    else $error("exec without select rise");
  a_no_exec_low: assert property (!load_select_n_i [*8] |-> !exec_o)
    else $error("exec while selected");
  // clear zeroes state asynchronously through rst_n; the five-cycle run only adds margin
  a_clear_zero: assert property (!async_clear_n_i [*5] |-> dac_code_o == 128'h0 && power_down_o == 8'h00)
    else $error("clear left state");
  a_clear_no_exec: assert property (!async_clear_n_i [*5] |-> !exec_o)
    else $error("exec under clear");
  a_code_cause: assert property ($changed(dac_code_o) |-> $past(exec_o) || !async_clear_n_i)
    else $error("code moved without exec");
  a_pd_cause: assert property ($changed(power_down_o) |-> $past(exec_o) || !async_clear_n_i)
    else $error("power-down moved without exec");
  a_chain_fall: assert property ($changed(serial_out_chain_o) |-> !$past(shift_clock_i) || !async_clear_n_i)
    else $error("chain out moved off a fall");
  c_exec: cover property (exec_o);
  c_all_down: cover property (power_down_o == 8'hff);
  c_chain: cover property ($rose(serial_out_chain_o));
endmodule
bind ocd_port ocd_port_properties u_ocd_port_properties (.*);

// ==== bench/ocd_host.sv ====
// host model driving frames into the port
`timescale 1ns/1ps
module ocd_host (
  input  wire logic   clk_sys_i, // clock
  input  wire logic   sdo_i,     // chain out
  output logic        sel_n_o,   // select
  output logic        sck_o,     // shift clock, idle low
  output logic        sdi_o,     // data
  output logic [31:0] got_o      // chain bits seen at rises
);
  initial begin
    sel_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
    got_o = 32'h0000_0000;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask
  // one frame msb first; 40 ns phases keep the port's sampler happy
  task automatic send(input logic [31:0] w, input int n);
    tick(1);
    sel_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = w[i];
      tick(4);
      sck_o = 1'b1;
      got_o = {got_o[30:0], sdo_i};
      tick(4);
      sck_o = 1'b0;
    end
    sdi_o = ~sdi_o; // no stale bit on a released line
    tick(2);
    sel_n_o = 1'b1;
    tick(10);
  endtask
  // clock pulses with select high
  task automatic stray();
    for (int i = 0; i < 4; i++) begin
      sdi_o = ~sdi_o;
      tick(4);
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
    end
  endtask
endmodule

// ==== bench/octal_dac_serial_command_port_tb.sv ====
// self-checking bench for the serial command port
`timescale 1ns/1ps
module octal_dac_serial_command_port_tb;
  logic         clk_sys_i = 1'b0;
  logic         resetn_i = 1'b0;
  logic         async_clear_n_i = 1'b1;
  wire          load_select_n_i, shift_clock_i, serial_in_i, serial_out_chain_o, exec_o;
  wire  [127:0] dac_code_o;
  wire  [7:0]   power_down_o;
  wire  [31:0]  got;
  logic [127:0] ec = 128'h0;
  logic [7:0]   ep = 8'h00;
  logic [15:0]  inr [8];
  int           fails = 0, n_compared = 0, n_exec = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  ocd_host u_ocd_host (.clk_sys_i(clk_sys_i), .sdo_i(serial_out_chain_o), .sel_n_o(load_select_n_i),
    .sck_o(shift_clock_i), .sdi_o(serial_in_i), .got_o(got));
  ocd_port u_ocd_port (.*);
  // exec count for the stray test; hang cut at the ceiling
  always @(posedge clk_sys_i) begin
    n_exec <= n_exec + int'(exec_o === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] seen);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one frame of n bits, 8'h5a filler on top only when n is 32, then the expected state
  task automatic run(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d, input int n);
    u_ocd_host.send({8'h5a, c, a, d}, n);
    for (int i = 0; i < 8; i++) begin
      if (a == i || a == 4'hf) begin
        if (c == 4'h0 || c == 4'h2 || c == 4'h3) inr[i] = d;
        if (c == 4'h1 || c == 4'h3) begin
          ec[i*16+:16] = inr[i];
          ep[i] = 1'b0;
        end
        if (c == 4'h4) ep[i] = 1'b1;
      end
      if (c == 4'h2) begin
        ec[i*16+:16] = inr[i];
        ep[i] = 1'b0;
      end
    end
    chk("code", ec, dac_code_o);
    chk("pd", {120'h0, ep}, {120'h0, power_down_o});
  endtask
  task automatic t_write();
    run(4'h0, 4'h0, 16'h8001, 24);
    run(4'h1, 4'h0, 16'hffff, 24);
    run(4'h3, 4'h7, 16'h1234, 32);
    $display("test write done");
  endtask
  task automatic t_power();
    run(4'h4, 4'hf, 16'hdead, 24);
    run(4'h2, 4'h5, 16'hbeef, 32);
    run(4'h4, 4'h2, 16'h0000, 24);
    run(4'h1, 4'hf, 16'h0000, 24);
    run(4'h6, 4'h1, 16'h5555, 24);
    run(4'h0, 4'h9, 16'h5555, 24);
    run(4'hf, 4'h3, 16'h5555, 24);
    $display("test power done");
  endtask
  task automatic t_stray();
    int e;
    e = n_exec;
    u_ocd_host.stray();
    chk("exec", 128'(e), 128'(n_exec));
    chk("code", ec, dac_code_o);
    $display("test stray done");
  endtask
  task automatic t_chain();
    u_ocd_host.send(32'ha5f0_1234, 32);
    u_ocd_host.send(32'h3cf7_0000, 32);
    chk("chain", {96'h0, 32'ha5f0_1234}, {96'h0, got});
    chk("code", ec, dac_code_o);
    $display("test chain done");
  endtask
  task automatic t_clear();
    async_clear_n_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1 async_clear_n_i = 1'b1;
    ec = 128'h0;
    ep = 8'h00;
    foreach (inr[i]) inr[i] = 16'h0000;
    run(4'h1, 4'hf, 16'h0000, 24);
    $display("test clear done");
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    foreach (inr[i]) inr[i] = 16'h0000;
    repeat (10) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk("code", 128'h0, dac_code_o);
    t_write();
    t_power();
    t_stray();
    t_chain();
    t_clear();
    end_of_test();
  end
endmodule
